// ---- verilog/sde_pkg.sv ----
// Shared constants and types of the serial data EEPROM slave.
// Assumes one system clock at the rate below; the link is sampled on it.
package sde_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ      = 125;
  localparam int PROG_TIME_US = 10000;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

  // ==========================================================================
  // Memory geometry
  localparam int ROW_W  = 5;
  localparam int WORD_W = 16;
  localparam int ROWS   = 32;
  localparam int PAGES  = 2;

  // ==========================================================================
  // Control byte values and modes
  localparam logic [7:0] CMD_PAGE1     = 8'h01;
  localparam logic [7:0] CMD_PAGE0     = 8'h09;
  localparam logic [7:0] CMD_FILL0     = 8'h11;
  localparam logic [7:0] CMD_FILL1     = 8'h19;
  localparam logic [1:0] MODE_LOW_INC  = 2'h1;
  localparam logic [1:0] MODE_HIGH_DEC = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] TX_LAST_BIT   = 3'h7;
  localparam logic [1:0] MAX_DATA      = 2'h2;

  // ==========================================================================
  // Register map
  localparam logic [3:0]  REG_STATUS      = 4'h0;
  localparam logic [3:0]  REG_CTRL        = 4'h4;
  localparam int          CTRL_LINK_EN    = 0;
  localparam logic        CTRL_LINK_EN_RV = 1'h1;
  localparam int          STAT_BUSY       = 0;
  localparam int          STAT_PAGE       = 1;
  localparam int          STAT_STANDBY    = 2;
  localparam int          STAT_ROW_LSB    = 4;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [ROW_W-1:0] row;
    logic             order_mode_bit_hi;
    logic             order_mode_bit_lo;
    logic             read_not_write_bit;
  } sde_ctrl_byte_t;

  typedef struct packed {
    logic [ROW_W-1:0] row;
    logic             standby;
    logic             page;
    logic             busy;
  } sde_status_t;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_RX    = 3'b001,
    LS_ACK   = 3'b010,
    LS_TX    = 3'b011,
    LS_TXACK = 3'b100,
    LS_WAIT  = 3'b101
  } sde_link_state_t;

  typedef enum logic [1:0] {
    PK_ROW   = 2'b00,
    PK_FILL0 = 2'b01,
    PK_FILL1 = 2'b10
  } sde_prog_kind_t;

endpackage

// ---- verilog/sde_eeprom_slave.sv ----
// Two-page data EEPROM behind a two-wire serial slave, with a register port.
// Assumes scl/sda come from an unrelated master and are synchronised here;
// the sda pin is open drain, pulled up outside.
//
// Overview of operation
// - Two pages, 32 rows of 16 bits
// - Control 01h selects page 1, 09h page 0
// - Data changes only while clock low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Start leaves standby, stop returns to it
// - Receiver pulls data low on ack pulse
// - Missing master ack ends transmission
// - Standby leaves data line undriven
// - Control byte: row, two mode bits, direction
// - Addressed row word copied into buffer
// - Mode bits choose buffer byte order
// - Write carries one or two data bytes
// - Programming erases then writes, about 10 ms
// - Busy device ignores link, withholds ack
// - Read control acked, word loaded, byte sent
// - 01 low first increment, 10 high decrement
// - Both bytes read steps row, reloads buffer
// - Row address wraps during sequential reads
// - Two reserved bytes fill page zero/one
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

module sde_eeprom_slave #(
  parameter int WRITE_CYCLES = sde_pkg::PROG_CYCLES
) (
  input  wire logic        mclk_i,      // System clock
  input  wire logic        rst_i,       // Synchronous reset, active high
  input  wire logic        scl_i,       // Serial link clock from master
  input  wire logic        sda_i,       // Serial data pin level
  output logic             sda_o,       // Serial data drive value
  output logic             sda_oe_o,    // High while pulling data low
  input  wire logic [3:0]  reg_addr_i,  // Register byte address
  input  wire logic [31:0] reg_wdata_i, // Register write data
  input  wire logic        reg_we_i,    // Register write strobe
  input  wire logic        reg_re_i,    // Register read strobe
  output logic [31:0]      reg_rdata_o, // Read data, cycle after strobe
  output logic             busy_o       // Programming in progress
);

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(WRITE_CYCLES / 2);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Halves must be distinct cycles
  if (WRITE_CYCLES < 8) begin : g_chk
    $error("WRITE_CYCLES must be at least 8");
  end

  // ==========================================================================
  // Link synchronisers
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ==========================================================================
  // State shared across concerns
  sde_pkg::sde_link_state_t state_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  rx_sh_q, tx_sh_q;
  logic [2:0]  tx_cnt_q;
  logic        first_q, ack_q, load_q, oe_q, link_en_q;
  logic        busy_q, page_q, rnw_q, special_q;
  logic [sde_pkg::ROW_W-1:0]  row_q;
  logic [1:0]  mode_q;
  logic [1:0]  byte_idx_q;
  logic [sde_pkg::WORD_W-1:0] buf_q;
  logic [sde_pkg::WORD_W-1:0] mem_q [sde_pkg::PAGES*sde_pkg::ROWS];
  sde_pkg::sde_ctrl_byte_t ctrl_w;
  assign ctrl_w = rx_sh_q;
  logic byte_done, ctrl_evt, ctrl_ok, data_ok, tx_start, tx_next, step_evt;
  logic is_page, is_fill, low_first, dec_mode, hi_sel;
  logic [7:0] tx_byte;
  logic [sde_pkg::ROW_W-1:0] next_row;
  assign byte_done = (state_q == sde_pkg::LS_RX) && scl_fall && (bit_cnt_q == sde_pkg::BITS_PER_BYTE);
  assign ctrl_evt  = byte_done && first_q;
  assign ctrl_ok   = ctrl_evt && !busy_q;
  assign data_ok   = byte_done && !first_q && !rnw_q && !special_q && (byte_idx_q < sde_pkg::MAX_DATA);
  assign is_page   = (rx_sh_q == sde_pkg::CMD_PAGE0) || (rx_sh_q == sde_pkg::CMD_PAGE1);
  assign is_fill   = (rx_sh_q == sde_pkg::CMD_FILL0) || (rx_sh_q == sde_pkg::CMD_FILL1);
  assign tx_start  = (state_q == sde_pkg::LS_ACK) && scl_fall && rnw_q && !special_q && first_q;
  assign tx_next   = (state_q == sde_pkg::LS_TXACK) && scl_fall && ack_q;
  assign step_evt  = tx_next && (byte_idx_q == 2'h1);
  assign low_first = (mode_q == sde_pkg::MODE_LOW_INC);
  assign dec_mode  = (mode_q == sde_pkg::MODE_HIGH_DEC);
  assign hi_sel    = (byte_idx_q == 2'h0) ? !low_first : low_first;
  assign tx_byte   = hi_sel ? buf_q[15:8] : buf_q[7:0];
  assign next_row  = dec_mode ? row_q - 5'h01 : row_q + 5'h01;

  // ==========================================================================
  // Link state machine
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q   <= sde_pkg::LS_IDLE;
      bit_cnt_q <= 4'h0;
      rx_sh_q   <= 8'h00;
      tx_sh_q   <= 8'h00;
      tx_cnt_q  <= 3'h0;
      first_q   <= 1'b0;
      ack_q     <= 1'b0;
      load_q    <= 1'b0;
      oe_q      <= 1'b0;
    end else if (!link_en_q || stop_det) begin
      state_q <= sde_pkg::LS_IDLE;
      oe_q    <= 1'b0;
      load_q  <= 1'b0;
    end else if (start_det) begin
      state_q   <= sde_pkg::LS_RX;
      bit_cnt_q <= 4'h0;
      first_q   <= 1'b1;
      oe_q      <= 1'b0;
      load_q    <= 1'b0;
    end else if (load_q) begin
      // Buffer settles one cycle before the first bit goes out
      load_q   <= 1'b0;
      tx_sh_q  <= tx_byte;
      oe_q     <= ~tx_byte[7];
      tx_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        sde_pkg::LS_RX: begin
          if (scl_rise && bit_cnt_q < sde_pkg::BITS_PER_BYTE) begin
            rx_sh_q   <= {rx_sh_q[6:0], sda_s_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (byte_done) begin
            if ((first_q && !busy_q) || data_ok) begin
              state_q <= sde_pkg::LS_ACK;
              oe_q    <= 1'b1;
            end else begin
              state_q <= sde_pkg::LS_WAIT;
            end
          end
        end
        sde_pkg::LS_ACK: begin
          if (scl_fall) begin
            oe_q <= 1'b0;
            if (tx_start) begin
              state_q <= sde_pkg::LS_TX;
              load_q  <= 1'b1;
            end else begin
              state_q   <= sde_pkg::LS_RX;
              bit_cnt_q <= 4'h0;
              first_q   <= 1'b0;
            end
          end
        end
        sde_pkg::LS_TX: begin
          if (scl_fall) begin
            if (tx_cnt_q == sde_pkg::TX_LAST_BIT) begin
              state_q <= sde_pkg::LS_TXACK;
              oe_q    <= 1'b0;
            end else begin
              tx_cnt_q <= tx_cnt_q + 3'h1;
              tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
              oe_q     <= ~tx_sh_q[6];
            end
          end
        end
        sde_pkg::LS_TXACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_s_q;
          end
          if (scl_fall) begin
            if (ack_q) begin
              state_q <= sde_pkg::LS_TX;
              load_q  <= 1'b1;
            end else begin
              state_q <= sde_pkg::LS_WAIT;
            end
          end
        end
        sde_pkg::LS_IDLE,
        sde_pkg::LS_WAIT: begin
          oe_q <= 1'b0;
        end
        default: begin
          state_q <= sde_pkg::LS_IDLE;
          oe_q    <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_q;

  // ==========================================================================
  // Row buffer, address and page
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      row_q      <= '0;
      mode_q     <= 2'h0;
      rnw_q      <= 1'b0;
      special_q  <= 1'b0;
      byte_idx_q <= 2'h0;
      buf_q      <= '0;
      page_q     <= 1'b0;
    end else if (ctrl_ok) begin
      row_q      <= ctrl_w.row;
      mode_q     <= {ctrl_w.order_mode_bit_hi, ctrl_w.order_mode_bit_lo};
      rnw_q      <= ctrl_w.read_not_write_bit;
      special_q  <= is_page || is_fill;
      byte_idx_q <= 2'h0;
      buf_q      <= mem_q[{page_q, ctrl_w.row}];
      if (rx_sh_q == sde_pkg::CMD_PAGE1) begin
        page_q <= 1'b1;
      end else if (rx_sh_q == sde_pkg::CMD_PAGE0) begin
        page_q <= 1'b0;
      end
    end else if (data_ok) begin
      byte_idx_q <= byte_idx_q + 2'h1;
      if (hi_sel) begin
        buf_q[15:8] <= rx_sh_q;
      end else begin
        buf_q[7:0] <= rx_sh_q;
      end
    end else if (step_evt) begin
      row_q      <= next_row;
      buf_q      <= mem_q[{page_q, next_row}];
      byte_idx_q <= 2'h0;
    end else if (tx_next) begin
      byte_idx_q <= 2'h1;
    end
  end

  // ==========================================================================
  // Programming cycle
  logic                   wr_pend_q, prog_page_q;
  sde_pkg::sde_prog_kind_t kind_q;
  logic [CNT_W-1:0]       prog_cnt_q;
  logic [sde_pkg::WORD_W-1:0] prog_word_q;
  logic [sde_pkg::ROW_W-1:0]  prog_row_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_pend_q   <= 1'b0;
      kind_q      <= sde_pkg::PK_ROW;
      prog_cnt_q  <= '0;
      prog_word_q <= '0;
      prog_row_q  <= '0;
      prog_page_q <= 1'b0;
      busy_q      <= 1'b0;
    end else if (busy_q) begin
      prog_cnt_q <= prog_cnt_q + 1'b1;
      if (prog_cnt_q == CNT_LAST) begin
        busy_q <= 1'b0;
      end
    end else if (stop_det && wr_pend_q) begin
      busy_q      <= 1'b1;
      wr_pend_q   <= 1'b0;
      prog_cnt_q  <= '0;
      prog_word_q <= buf_q;
      prog_row_q  <= row_q;
      prog_page_q <= page_q;
    end else if (start_det) begin
      // An unfinished write is dropped by a repeated start
      wr_pend_q <= 1'b0;
    end else if (ctrl_ok && is_fill) begin
      wr_pend_q <= 1'b1;
      kind_q    <= (rx_sh_q == sde_pkg::CMD_FILL1) ? sde_pkg::PK_FILL1 : sde_pkg::PK_FILL0;
    end else if (ctrl_ok) begin
      kind_q <= sde_pkg::PK_ROW;
    end else if (data_ok) begin
      wr_pend_q <= 1'b1;
    end
  end

  assign busy_o = busy_q;

  // ==========================================================================
  // Cell array: erase to zero first, then set ones at half time
  always_ff @(posedge mclk_i) begin
    if (busy_q && prog_cnt_q == '0) begin
      if (kind_q == sde_pkg::PK_ROW) begin
        mem_q[{prog_page_q, prog_row_q}] <= '0;
      end else begin
        for (int r = 0; r < sde_pkg::ROWS; r++) begin
          mem_q[{prog_page_q, 5'(r)}] <= '0;
        end
      end
    end else if (busy_q && prog_cnt_q == CNT_HALF) begin
      if (kind_q == sde_pkg::PK_ROW) begin
        mem_q[{prog_page_q, prog_row_q}] <= prog_word_q;
      end else if (kind_q == sde_pkg::PK_FILL1) begin
        for (int r = 0; r < sde_pkg::ROWS; r++) begin
          mem_q[{prog_page_q, 5'(r)}] <= '1;
        end
      end
    end
  end

  // ==========================================================================
  // Register port
  sde_pkg::sde_status_t status_w;
  assign status_w = '{row: row_q, standby: (state_q == sde_pkg::LS_IDLE), page: page_q, busy: busy_q};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      link_en_q <= sde_pkg::CTRL_LINK_EN_RV;
    end else if (reg_we_i && reg_addr_i == sde_pkg::REG_CTRL) begin
      link_en_q <= reg_wdata_i[sde_pkg::CTRL_LINK_EN];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_re_i && reg_addr_i == sde_pkg::REG_STATUS) begin
      reg_rdata_o <= {23'h0, status_w.row, 1'b0, status_w.standby, status_w.page, status_w.busy};
    end else if (reg_re_i && reg_addr_i == sde_pkg::REG_CTRL) begin
      reg_rdata_o <= {31'h0, link_en_q};
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ==========================================================================
  // Checks
  property p_standby_quiet;
    (state_q == sde_pkg::LS_IDLE) |=> !sda_oe_o;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("data driven in standby");
  property p_start_wakes;
    (start_det && link_en_q && !stop_det) |=> (state_q == sde_pkg::LS_RX) && first_q;
  endproperty
  a_start_wakes: assert property (p_start_wakes) else $error("start not taken");
  property p_stop_sleeps;
    stop_det |=> (state_q == sde_pkg::LS_IDLE) && !sda_oe_o;
  endproperty
  a_stop_sleeps: assert property (p_stop_sleeps) else $error("stop not taken");
  property p_busy_nack;
    (ctrl_evt && busy_q && !start_det && !stop_det && link_en_q) |=> (state_q == sde_pkg::LS_WAIT) && !sda_oe_o;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("control acked while busy");
  property p_prog_hold;
    $rose(busy_q) |-> busy_q [*8];
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("program cycle too short");
  property p_ack_pull;
    (byte_done && data_ok && link_en_q && !start_det && !stop_det) |=> sda_oe_o && (state_q == sde_pkg::LS_ACK);
  endproperty
  a_ack_pull: assert property (p_ack_pull) else $error("data byte not acked");
  property p_nack_ends;
    ((state_q == sde_pkg::LS_TXACK) && scl_fall && !ack_q && link_en_q && !start_det && !stop_det)
      |=> (state_q == sde_pkg::LS_WAIT) ##1 !sda_oe_o;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("sent after nack");
  property p_row_step;
    (step_evt && !ctrl_ok && !data_ok) |=> (row_q == ($past(dec_mode) ? $past(row_q) - 5'h01 : $past(row_q) + 5'h01));
  endproperty
  a_row_step: assert property (p_row_step) else $error("row not stepped");
  property p_change_low;
    ($changed(sda_oe_o) && state_q != sde_pkg::LS_IDLE && !$past(start_det)) |-> !scl_s_q;
  endproperty
  a_change_low: assert property (p_change_low) else $error("data changed with clock high");
  property p_page_sel;
    (ctrl_ok && rx_sh_q == sde_pkg::CMD_PAGE0) |=> !page_q ##1 !page_q;
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("page 0 not selected");

endmodule

// ---- verification/sde_link_master.sv ----
// Behavioural two-wire master that drives the slave's link pins.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps

module sde_link_master (
  input  wire logic mclk_i,     // System clock paces the link
  input  wire logic sda_i,      // Resolved data wire level
  output logic      scl_o,      // Link clock, stands high when idle
  output logic      sda_pull_o  // High while pulling data low
);
  // ==========================================================================
  // Bit timing: 5 mclk per half period gives the 80 ns link clock
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic half();
    repeat (5) @(posedge mclk_i);
  endtask

  // Data moves one cycle after the clock fall so the two never coincide
  task automatic put_bit(input logic b, output logic r);
    @(posedge mclk_i);
    sda_pull_o <= ~b;
    repeat (4) @(posedge mclk_i);
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  // ==========================================================================
  // Frame conditions
  task automatic start();
    @(posedge mclk_i);
    sda_pull_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
    scl_o <= 1'b1;
    half();
    sda_pull_o <= 1'b1;
    half();
    scl_o <= 1'b0;
  endtask

  task automatic stop();
    @(posedge mclk_i);
    sda_pull_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    scl_o <= 1'b1;
    half();
    sda_pull_o <= 1'b0;
    half();
  endtask

  // ==========================================================================
  // Bytes, most significant bit first
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(~ack, r);
  endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench: link master model plus register port tasks.
// Assumes a shortened programming time so the run stays brief.
`timescale 1ns/100ps

module tb;
  localparam int         WC    = 400;
  localparam int         LIMIT = 30000;
  localparam logic [1:0] LI    = sde_pkg::MODE_LOW_INC;
  localparam logic [1:0] HD    = sde_pkg::MODE_HIGH_DEC;

  logic        mclk;
  logic        rst;
  logic        scl;
  logic        m_pull;
  logic        sda_w;
  logic        dev_sda;
  logic        dev_oe;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [31:0] reg_rdata;
  logic        busy;
  int          num_errors;
  int          n_tests;
  int          cyc;
  int          bcnt;
  int          cnt;
  logic        ack;
  logic [31:0] rd;

  // Open-drain wire with pull-up
  assign sda_w = ~m_pull & (dev_oe ? dev_sda : 1'b1);

  sde_eeprom_slave #(.WRITE_CYCLES(WC)) u_sde_eeprom_slave (
    .mclk_i      (mclk),
    .rst_i       (rst),
    .scl_i       (scl),
    .sda_i       (sda_w),
    .sda_o       (dev_sda),
    .sda_oe_o    (dev_oe),
    .reg_addr_i  (reg_addr),
    .reg_wdata_i (reg_wdata),
    .reg_we_i    (reg_we),
    .reg_re_i    (reg_re),
    .reg_rdata_o (reg_rdata),
    .busy_o      (busy)
  );

  sde_link_master u_sde_link_master (
    .mclk_i     (mclk),
    .sda_i      (sda_w),
    .scl_o      (scl),
    .sda_pull_o (m_pull)
  );

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // ==========================================================================
  // Checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) begin
      bcnt <= bcnt + 1;
    end
    if (cyc == LIMIT) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Register port
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  // ==========================================================================
  // Link transfers
  task automatic wr_row(input logic [7:0] ctrl, input int n, input logic [23:0] d, input logic bsy);
    u_sde_link_master.start();
    u_sde_link_master.wr_byte(ctrl, ack);
    check(ack, 1);
    for (int i = 0; i < n; i++) begin
      u_sde_link_master.wr_byte(d[23-8*i -: 8], ack);
      check(ack, i < 2);
    end
    bcnt = 0;
    u_sde_link_master.stop();
    check(busy, bsy);
    if (bsy) begin
      u_sde_link_master.start();
      u_sde_link_master.wr_byte(ctrl, ack);
      check(ack, 0);
      u_sde_link_master.stop();
    end
    cnt = 0;
    while (busy === 1'b1 && cnt < 2 * WC) begin
      @(posedge mclk);
      cnt++;
    end
    @(posedge mclk);
    check(busy, 0);
    if (bsy) begin
      check(bcnt >= WC - 1 && bcnt <= WC + 1, 1);
    end
  endtask

  task automatic rd_chk(input logic [7:0] ctrl, input int n, input logic [63:0] e);
    logic [7:0] b;
    u_sde_link_master.start();
    u_sde_link_master.wr_byte(ctrl, ack);
    check(ack, 1);
    for (int i = 0; i < n; i++) begin
      u_sde_link_master.rd_byte(i < n - 1, b);
      check(b, e[63-8*i -: 8]);
    end
    u_sde_link_master.stop();
    check(dev_oe, 0);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst        = 1'b1;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0000_0000;
    reg_we     = 1'b0;
    reg_re     = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    cyc        = 0;
    bcnt       = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    reg_rd(sde_pkg::REG_STATUS, rd);
    check(rd[2:0], 3'h4);
    reg_rd(sde_pkg::REG_CTRL, rd);
    check(rd[0], sde_pkg::CTRL_LINK_EN_RV);
    reg_rd(4'h8, rd);
    check(rd, 32'h0000_0000);
    check(dev_oe, 0);
    u_sde_link_master.start();
    reg_rd(sde_pkg::REG_STATUS, rd);
    check(rd[2], 0);
    u_sde_link_master.stop();
    reg_rd(sde_pkg::REG_STATUS, rd);
    check(rd[2], 1);
    // Link disabled by software: control byte must go unanswered
    reg_wr(sde_pkg::REG_CTRL, 32'h0000_0000);
    u_sde_link_master.start();
    u_sde_link_master.wr_byte(8'h03, ack);
    check(ack, 0);
    u_sde_link_master.stop();
    reg_wr(sde_pkg::REG_CTRL, 32'h0000_0001);
    wr_row(sde_pkg::CMD_FILL0, 0, 24'h0, 1);
    wr_row({5'd31, LI, 1'b0}, 2, 24'h341200, 1);
    wr_row({5'd0, HD, 1'b0}, 2, 24'hABCD00, 1);
    wr_row({5'd1, LI, 1'b0}, 1, 24'h5A0000, 1);
    // Rows 0 to 3 read in order 00 are the reserved page and fill bytes
    wr_row({5'd5, 2'b00, 1'b0}, 3, 24'h112233, 1);
    wr_row({5'd3, LI, 1'b0}, 0, 24'h0, 0);
    rd_chk({5'd30, LI, 1'b1}, 8, 64'h0000_3412_CDAB_5A00);
    rd_chk({5'd0, HD, 1'b1}, 4, 64'hABCD_1234_0000_0000);
    rd_chk({5'd5, 2'b00, 1'b1}, 3, 64'h1122_0000_0000_0000);
    rd_chk({5'd1, LI, 1'b1}, 1, 64'h5A00_0000_0000_0000);
    wr_row(sde_pkg::CMD_PAGE1, 0, 24'h0, 0);
    reg_rd(sde_pkg::REG_STATUS, rd);
    check(rd[1], 1);
    wr_row(sde_pkg::CMD_FILL1, 0, 24'h0, 1);
    rd_chk({5'd31, LI, 1'b1}, 2, 64'hFFFF_0000_0000_0000);
    wr_row(sde_pkg::CMD_PAGE0, 0, 24'h0, 0);
    reg_rd(sde_pkg::REG_STATUS, rd);
    check(rd[1], 0);
    rd_chk({5'd31, LI, 1'b1}, 2, 64'h3412_0000_0000_0000);
    report_and_stop();
  end
endmodule
